// ### shared/memmap_pkg.sv
// Purpose: constants and types for the memory map and register paging block
// Assumes: 8-bit core, byte-wide internal spaces
// Notes: addresses are byte addresses in their own space
package memmap_pkg;
  localparam logic [15:0] CODE_TOP_32K = 16'h7fff;
  localparam logic [15:0] CODE_TOP_16K = 16'h3fff;
  localparam logic [15:0] LOCK_32K = 16'h7bff;
  localparam logic [15:0] LOCK_16K = 16'h3fff;
  localparam int EXPANSION_RAM_BYTES = 2048;
  localparam int EXPANSION_RAM_AW = 11;
  localparam logic [7:0] DIRECT_TOP = 8'h7f;
  localparam logic [7:0] BANK_TOP = 8'h1f;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] PAGE_MAIN = 8'h00;
  localparam logic [7:0] PAGE_CAN = 8'h0c;
  localparam logic [7:0] PAGE_CFG = 8'h0f;
  localparam logic [7:0] ADDR_PAGE_SELECT = 8'ha7;
  localparam logic [7:0] ADDR_PAGE_CONTROL = 8'h84;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_PORT_A = 8'h80;
  localparam logic [7:0] ADDR_PORT_B = 8'h90;
  localparam logic [7:0] ADDR_PORT_C = 8'ha0;
  localparam logic [7:0] ADDR_PORT_D = 8'hb0;
  localparam logic [7:0] ADDR_STACK_MIDDLE = 8'h85;
  localparam logic [7:0] ADDR_STACK_BOTTOM = 8'h86;
  localparam int BANK_LO_BIT = 3;
  localparam int BANK_HI_BIT = 4;
  localparam logic [7:0] PAGE_CONTROL_RESET = 8'h01;
  typedef enum logic [2:0] {
    TGT_NONE, TGT_IRAM, TGT_SFR, TGT_EXPANSION_RAM, TGT_FLASH
  } target_t;
endpackage

// ### shared/iram_if.sv
// Purpose: port bundle between the decoder and the internal RAM
// Assumes: one access per cycle
// Notes: read data comes back one cycle after the request
`timescale 1ns/10ps
`default_nettype none
interface iram_if;
  logic we;
  logic re;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output we, output re, output addr, output wdata, input rdata);
  modport slave (input we, input re, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### rtl/iram_store.sv
// Purpose: 256-byte internal RAM with registered read data
// Assumes: write and read on the same clock
// Notes: no reset on contents
`timescale 1ns/10ps
`default_nettype none
module iram_store #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  iram_if.slave mem
);
  logic [7:0] store [DEPTH];
  if (DEPTH != 256) begin : g_bad_depth
    $error("iram_store depth must be 256");
  end
  always_ff @(posedge clk) begin
    if (mem.we) begin
      store[mem.addr] <= mem.wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (mem.re) begin
      mem.rdata <= store[mem.addr];
    end
  end
endmodule
`default_nettype wire

// ### rtl/memory_map.sv
// Purpose: memory space decode, internal RAM access and register paging
// Assumes: core presents one access per cycle, events are one-cycle pulses
// Notes: internal RAM read data appears one cycle after the request
//
// Functional notes
// - flash backs code space up to variant top
// - lock byte location; above it reserved on 32K only
// - code moves read flash; external writes steerable
// - 2048-byte expansion RAM in external space
// - internal RAM 0x00-0xff; lower half both modes
// - above 0x7f: direct is register, indirect RAM
// - four banks of eight, chosen by status bits
// - indirect pointer from bank register zero/one
// - bytes 0x20-0x2f also as 128 bits
// - push writes pointer+1 then increments
// - stack pointer resets to 0x07
// - registers at x0/x8 are bit-addressable
// - 256 pages, only 0x00, 0x0c, 0x0f populated
// - entry pushes page stack then loads page
// - entry page 0x00, can source 0x0c
// - return pops stack; bottom refills zero
// - software stack writes never push or pop
// - auto paging enable, set by reset
// - all-page registers decode on any page
// - page control at 0x84 page 0x0f, bit 0
// - page select at 0xa7, all pages, reset 0
// - enable clear stops switch and push/pop
`timescale 1ns/10ps
`default_nettype none
module memory_map #(
  parameter bit FLASH_32K = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  // code space
  input wire logic [15:0] codeAddr,
  input wire logic codeRead,
  // external space
  input wire logic [15:0] extAddr,
  input wire logic extRead,
  input wire logic extWrite,
  input wire logic flashWriteMode,
  // data space access: direct or indirect, byte or bit
  input wire logic dataRead,
  input wire logic dataWrite,
  input wire logic indirect,
  input wire logic indirectViaOne,
  input wire logic bitAccess,
  input wire logic [7:0] dataAddr,
  input wire logic [7:0] dataWdata,
  input wire logic bitWdata,
  // stack push request
  input wire logic push,
  input wire logic [7:0] pushData,
  // interrupt events
  input wire logic intEntry,
  input wire logic intFromCan,
  input wire logic intReturn,
  // code / external decode results
  output logic flashRead,
  output logic [15:0] flashAddr,
  output logic lockByteHit,
  output logic codeReserved,
  output logic xramRead,
  output logic xramWrite,
  output logic flashWrite,
  output logic [10:0] xramAddr,
  // external register strobes
  output logic sfrRead,
  output logic sfrWrite,
  output logic sfrBitAccess,
  output logic sfrUnoccupied,
  output logic [7:0] sfrAddr,
  output logic [7:0] page_select,
  output logic [7:0] sfrWdata,
  // internal read data
  output logic [7:0] dataRdata,
  output logic dataRvalid,
  // visible state
  output logic [7:0] pageSelect,
  output logic [7:0] pageStackMiddle,
  output logic [7:0] pageStackBottom,
  output logic autoPageEnable,
  output logic [7:0] stackPointer,
  output logic [7:0] programStatusWord
);
  if (memmap_pkg::EXPANSION_RAM_BYTES != (1 << memmap_pkg::EXPANSION_RAM_AW)) begin : g_bad_expansion_ram
    $error("expansion_ram size mismatch");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] r);
    bank_addr = {3'h0, bank, r};
  endfunction

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] pg,
                                  input logic [7:0] where, input logic [7:0] page);
    regHit = (a == where) && (pg == page);
  endfunction

  function automatic logic allPage(input logic [7:0] a);
    allPage = (a == memmap_pkg::ADDR_PORT_A) || (a == memmap_pkg::ADDR_PORT_B) ||
              (a == memmap_pkg::ADDR_PORT_C) || (a == memmap_pkg::ADDR_PORT_D) ||
              (a == memmap_pkg::ADDR_PAGE_SELECT) || (a == memmap_pkg::ADDR_STACK_POINTER) ||
              (a == memmap_pkg::ADDR_STATUS_WORD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] page_r, middle_r, bottom_r, sp_r, psw_r;
  logic [7:0] portA_r, portB_r, portC_r, portD_r;
  logic autoEn_r;
  logic [1:0] bank;
  iram_if ram ();

  assign bank = {psw_r[memmap_pkg::BANK_HI_BIT], psw_r[memmap_pkg::BANK_LO_BIT]};

  iram_store #(.DEPTH(256)) u_iram (
    .clk(clk),
    .mem(ram.slave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // data space decode
  logic [7:0] ptrAddr, effAddr, byteAddr;
  logic [2:0] bitPos;
  logic toSfr, known, bitOk;
  logic [7:0] regVal;
  logic regHitAny;

  // indirect pointer read: bank register value kept in a shadow of RAM
  logic [7:0] ptrZero_r [4];
  logic [7:0] ptrOne_r [4];

  always_comb begin
    ptrAddr = indirectViaOne ? ptrOne_r[bank] : ptrZero_r[bank];
    effAddr = indirect ? ptrAddr : dataAddr;
    toSfr = !indirect && (effAddr > memmap_pkg::DIRECT_TOP);
    bitPos = effAddr[2:0];
    if (bitAccess && !toSfr && !indirect) begin
      byteAddr = memmap_pkg::BIT_BASE + {4'h0, effAddr[6:3]};
    end else if (bitAccess) begin
      byteAddr = {effAddr[7:3], 3'h0};
    end else begin
      byteAddr = effAddr;
    end
    bitOk = !bitAccess || !toSfr || (byteAddr[2:0] == 3'h0);
  end

  // internal register decode
  always_comb begin
    regHitAny = 1'b1;
    regVal = 8'h00;
    if (byteAddr == memmap_pkg::ADDR_PAGE_SELECT) begin
      regVal = page_r;
    end else if (byteAddr == memmap_pkg::ADDR_STACK_POINTER) begin
      regVal = sp_r;
    end else if (byteAddr == memmap_pkg::ADDR_STATUS_WORD) begin
      regVal = psw_r;
    end else if (byteAddr == memmap_pkg::ADDR_PORT_A) begin
      regVal = portA_r;
    end else if (byteAddr == memmap_pkg::ADDR_PORT_B) begin
      regVal = portB_r;
    end else if (byteAddr == memmap_pkg::ADDR_PORT_C) begin
      regVal = portC_r;
    end else if (byteAddr == memmap_pkg::ADDR_PORT_D) begin
      regVal = portD_r;
    end else if (regHit(byteAddr, page_r, memmap_pkg::ADDR_PAGE_CONTROL, memmap_pkg::PAGE_CFG)) begin
      regVal = {7'h00, autoEn_r};
    end else if (regHit(byteAddr, page_r, memmap_pkg::ADDR_STACK_MIDDLE, memmap_pkg::PAGE_CFG)) begin
      regVal = middle_r;
    end else if (regHit(byteAddr, page_r, memmap_pkg::ADDR_STACK_BOTTOM, memmap_pkg::PAGE_CFG)) begin
      regVal = bottom_r;
    end else begin
      regHitAny = 1'b0;
    end
  end

  assign known = (page_r == memmap_pkg::PAGE_MAIN) || (page_r == memmap_pkg::PAGE_CAN) ||
                 (page_r == memmap_pkg::PAGE_CFG) || allPage(byteAddr);

  logic localWr;
  logic [7:0] wrByte;
  assign localWr = dataWrite && toSfr && regHitAny && bitOk;
  always_comb begin
    wrByte = dataWdata;
    if (bitAccess) begin
      wrByte = regVal;
      wrByte[bitPos] = bitWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page stack
  always_ff @(posedge clk) begin
    if (rst) begin
      page_r <= memmap_pkg::PAGE_MAIN;
      middle_r <= 8'h00;
      bottom_r <= 8'h00;
    end else if (intEntry && autoEn_r) begin
      middle_r <= page_r;
      bottom_r <= middle_r;
      page_r <= intFromCan ? memmap_pkg::PAGE_CAN : memmap_pkg::PAGE_MAIN;
    end else if (intReturn && autoEn_r) begin
      page_r <= middle_r;
      middle_r <= bottom_r;
      bottom_r <= 8'h00;
    end else if (localWr) begin
      if (byteAddr == memmap_pkg::ADDR_PAGE_SELECT) page_r <= wrByte;
      if (regHit(byteAddr, page_r, memmap_pkg::ADDR_STACK_MIDDLE, memmap_pkg::PAGE_CFG)) begin
        middle_r <= wrByte;
      end
      if (regHit(byteAddr, page_r, memmap_pkg::ADDR_STACK_BOTTOM, memmap_pkg::PAGE_CFG)) begin
        bottom_r <= wrByte;
      end
    end
  end

  // auto paging enable; entry/return gated above
  always_ff @(posedge clk) begin
    if (rst) begin
      autoEn_r <= memmap_pkg::PAGE_CONTROL_RESET[0];
    end else if (localWr &&
                 regHit(byteAddr, page_r, memmap_pkg::ADDR_PAGE_CONTROL, memmap_pkg::PAGE_CFG)) begin
      autoEn_r <= wrByte[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer, status word, port registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_r <= memmap_pkg::SP_RESET;
    end else if (push) begin
      sp_r <= sp_r + 8'h01;
    end else if (localWr && byteAddr == memmap_pkg::ADDR_STACK_POINTER) begin
      sp_r <= wrByte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      psw_r <= 8'h00;
      portA_r <= 8'hff;
      portB_r <= 8'hff;
      portC_r <= 8'hff;
      portD_r <= 8'hff;
    end else if (localWr) begin
      if (byteAddr == memmap_pkg::ADDR_STATUS_WORD) psw_r <= wrByte;
      if (byteAddr == memmap_pkg::ADDR_PORT_A) portA_r <= wrByte;
      if (byteAddr == memmap_pkg::ADDR_PORT_B) portB_r <= wrByte;
      if (byteAddr == memmap_pkg::ADDR_PORT_C) portC_r <= wrByte;
      if (byteAddr == memmap_pkg::ADDR_PORT_D) portD_r <= wrByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal RAM port
  logic ramWr, ramRd;
  logic [7:0] bitMask;
  logic [7:0] bitMerged;
  logic [7:0] bitRam_r [16];
  logic bitPend_r, regPend_r, extPend_r;
  logic [2:0] bitPos_r;
  logic [7:0] regVal_r;
  assign bitMask = 8'h01 << bitPos;
  // bit writes store the merged byte so byte reads see them
  assign bitMerged = (bitRam_r[byteAddr[3:0]] & ~bitMask) | (bitWdata ? bitMask : 8'h00);
  assign ramWr = push || (dataWrite && !toSfr);
  assign ramRd = dataRead && !toSfr;

  always_comb begin
    ram.we = ramWr;
    ram.re = ramRd;
    ram.addr = push ? sp_r + 8'h01 : byteAddr;
    ram.wdata = push ? pushData : (bitAccess ? bitMerged : dataWdata);
  end

  // shadow of bank registers zero and one for pointer fetch
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        ptrZero_r[i] <= 8'h00;
        ptrOne_r[i] <= 8'h00;
      end
    end else if (ramWr) begin
      for (int i = 0; i < 4; i++) begin
        if (ram.addr == bank_addr(2'(i), 3'h0)) ptrZero_r[i] <= ram.wdata;
        if (ram.addr == bank_addr(2'(i), 3'h1)) ptrOne_r[i] <= ram.wdata;
      end
    end
  end

  // bit area shadow follows every RAM write into the bit bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) bitRam_r[i] <= 8'h00;
    end else if (ramWr && ram.addr[7:4] == memmap_pkg::BIT_BASE[7:4]) begin
      bitRam_r[ram.addr[3:0]] <= ram.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bitPend_r <= 1'b0;
      regPend_r <= 1'b0;
      extPend_r <= 1'b0;
      bitPos_r <= 3'h0;
      regVal_r <= 8'h00;
      dataRvalid <= 1'b0;
    end else begin
      bitPend_r <= dataRead && bitAccess;
      regPend_r <= dataRead && toSfr;
      extPend_r <= dataRead && toSfr && !regHitAny;
      bitPos_r <= bitPos;
      regVal_r <= bitAccess && !toSfr ? bitRam_r[byteAddr[3:0]] : regVal;
      dataRvalid <= dataRead && (!toSfr || regHitAny);
    end
  end

  always_comb begin
    if (bitPend_r) dataRdata = {7'h00, regVal_r[bitPos_r]};
    else if (regPend_r) dataRdata = extPend_r ? 8'h00 : regVal_r;
    else dataRdata = ram.rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // code, external and register strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      flashRead <= 1'b0;
      flashAddr <= 16'h0000;
      lockByteHit <= 1'b0;
      codeReserved <= 1'b0;
      xramRead <= 1'b0;
      xramWrite <= 1'b0;
      flashWrite <= 1'b0;
      xramAddr <= 11'h000;
      sfrRead <= 1'b0;
      sfrWrite <= 1'b0;
      sfrBitAccess <= 1'b0;
      sfrUnoccupied <= 1'b0;
      sfrAddr <= 8'h00;
      sfrWdata <= 8'h00;
    end else begin
      flashRead <= codeRead && (codeAddr <= (FLASH_32K ? memmap_pkg::CODE_TOP_32K
                                                       : memmap_pkg::CODE_TOP_16K));
      flashAddr <= extWrite && flashWriteMode ? extAddr : codeAddr;
      lockByteHit <= codeRead && codeAddr == (FLASH_32K ? memmap_pkg::LOCK_32K
                                                        : memmap_pkg::LOCK_16K);
      codeReserved <= codeRead && FLASH_32K && codeAddr > memmap_pkg::LOCK_32K;
      xramRead <= extRead;
      xramWrite <= extWrite && !flashWriteMode;
      flashWrite <= extWrite && flashWriteMode;
      xramAddr <= extAddr[memmap_pkg::EXPANSION_RAM_AW-1:0];
      sfrRead <= dataRead && toSfr && !regHitAny;
      sfrWrite <= dataWrite && toSfr && !regHitAny && bitOk;
      sfrBitAccess <= bitAccess && toSfr && bitOk;
      sfrUnoccupied <= (dataRead || dataWrite) && toSfr && (!known || !bitOk);
      sfrAddr <= byteAddr;
      sfrWdata <= dataWdata;
    end
  end

  assign page_select = page_r;
  assign pageSelect = page_r;
  assign pageStackMiddle = middle_r;
  assign pageStackBottom = bottom_r;
  assign autoPageEnable = autoEn_r;
  assign stackPointer = sp_r;
  assign programStatusWord = psw_r;
endmodule
`default_nettype wire

// ### verif/sfr_model.sv
// Purpose: far-side register stub that records paged register writes
// Assumes: strobes arrive one cycle after the core request
// Notes: keeps the last write so the bench can inspect it
`timescale 1ns/10ps
`default_nettype none
module sfr_model (
  input wire logic clk,
  input wire logic sfrWrite,
  input wire logic [7:0] page_select,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata
);
  logic [7:0] lastData = 8'h00;
  logic [7:0] lastAddr = 8'h00;
  logic [7:0] lastPage = 8'hff;
  // a write lands on the page in force at the strobe
  always_ff @(posedge clk) begin
    if (sfrWrite) begin
      lastData <= sfrWdata;
      lastAddr <= sfrAddr;
      lastPage <= page_select;
    end
  end
endmodule
`default_nettype wire

// ### verif/memory_map_props.sv
// Purpose: port-level properties of the memory map block
// Assumes: one clock, synchronous reset
// Notes: bound to every memory_map instance
`timescale 1ns/10ps
`default_nettype none
module memory_map_props #(
  parameter bit FLASH_32K = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] codeAddr,
  input wire logic codeRead,
  input wire logic extWrite,
  input wire logic flashWriteMode,
  input wire logic dataRead,
  input wire logic dataWrite,
  input wire logic indirect,
  input wire logic bitAccess,
  input wire logic [7:0] dataAddr,
  input wire logic [7:0] dataWdata,
  input wire logic push,
  input wire logic intEntry,
  input wire logic intFromCan,
  input wire logic intReturn,
  input wire logic flashRead,
  input wire logic [15:0] flashAddr,
  input wire logic lockByteHit,
  input wire logic xramWrite,
  input wire logic flashWrite,
  input wire logic sfrWrite,
  input wire logic sfrBitAccess,
  input wire logic [7:0] sfrAddr,
  input wire logic dataRvalid,
  input wire logic [7:0] pageSelect,
  input wire logic [7:0] pageStackMiddle,
  input wire logic [7:0] pageStackBottom,
  input wire logic autoPageEnable,
  input wire logic [7:0] stackPointer
);
  localparam logic [15:0] LOCK = FLASH_32K ? memmap_pkg::LOCK_32K : memmap_pkg::LOCK_16K;
  localparam logic [15:0] TOP = FLASH_32K ? memmap_pkg::CODE_TOP_32K : memmap_pkg::CODE_TOP_16K;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence entryEv;
    intEntry && autoPageEnable;
  endsequence
  sequence returnEv;
    intReturn && !intEntry && autoPageEnable;
  endsequence
  a_reset_state: assert property (
    $past(rst) |-> stackPointer == 8'h07 && pageSelect == 8'h00 && autoPageEnable
      && pageStackMiddle == 8'h00 && pageStackBottom == 8'h00)
    else $error("state after reset wrong");
  a_entry_push: assert property (
    entryEv |=> pageStackMiddle == $past(pageSelect) && pageStackBottom == $past(pageStackMiddle))
    else $error("entry did not push page stack");
  a_entry_page: assert property (
    entryEv |=> pageSelect == ($past(intFromCan) ? memmap_pkg::PAGE_CAN : memmap_pkg::PAGE_MAIN))
    else $error("entry loaded wrong page");
  a_return_pop: assert property (
    returnEv |=> pageSelect == $past(pageStackMiddle)
      && pageStackMiddle == $past(pageStackBottom) && pageStackBottom == 8'h00)
    else $error("return did not pop page stack");
  a_auto_off: assert property (
    !autoPageEnable && (intEntry || intReturn) && !dataWrite |=> $stable(pageSelect)
      && $stable(pageStackMiddle) && $stable(pageStackBottom))
    else $error("page stack moved while disabled");
  a_push_step: assert property (
    push && !dataWrite |=> stackPointer == $past(stackPointer) + 8'h01)
    else $error("push did not step pointer");
  a_read_valid: assert property (
    dataRead && (indirect || dataAddr <= 8'h7f) |=> dataRvalid)
    else $error("ram read gave no data");
  a_direct_only: assert property (
    sfrWrite |-> sfrAddr[7] && $past(dataWrite && !indirect))
    else $error("register strobe without direct access");
  a_bit_aligned: assert property (
    sfrBitAccess |-> sfrAddr[2:0] == 3'h0)
    else $error("bit access to unaligned register");
  a_code_flash: assert property (
    codeRead && codeAddr <= TOP |=> flashRead && flashAddr == $past(codeAddr))
    else $error("code read missed flash");
  a_lock_byte: assert property (
    codeRead && codeAddr == LOCK |=> lockByteHit)
    else $error("lock byte not flagged");
  a_ext_steer: assert property (
    extWrite |=> flashWrite == $past(flashWriteMode) && xramWrite == !$past(flashWriteMode))
    else $error("external write steered wrongly");
  a_page_write: assert property (
    dataWrite && !indirect && !bitAccess && dataAddr == 8'ha7 && !intEntry && !intReturn
      |=> pageSelect == $past(dataWdata))
    else $error("page select write lost");
endmodule
bind memory_map memory_map_props #(.FLASH_32K(FLASH_32K)) props (.*);
`default_nettype wire

// ### verif/tb.sv
// Purpose: self-checking bench for the memory map block
// Assumes: requests are one-cycle pulses, answers one cycle later
// Notes: register stub sits on the external strobes
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, rst, codeRead, extRead, extWrite, flashWriteMode, dataRead, dataWrite;
  logic indirect, indirectViaOne, bitAccess, bitWdata, push, intEntry, intFromCan, intReturn;
  logic [15:0] codeAddr, extAddr, flashAddr;
  logic [7:0] dataAddr, dataWdata, pushData, sfrAddr, page_select, sfrWdata, dataRdata;
  logic [7:0] pageSelect, pageStackMiddle, pageStackBottom, stackPointer, programStatusWord;
  logic flashRead, lockByteHit, codeReserved, xramRead, xramWrite, flashWrite;
  logic sfrRead, sfrWrite, sfrBitAccess, sfrUnoccupied, dataRvalid, autoPageEnable;
  logic [10:0] xramAddr;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  memory_map #(.FLASH_32K(1'b1)) uut (.*);
  sfr_model model (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic dacc(input logic wr, ind, one, bt, input logic [7:0] a, d);
    @(posedge clk);
    dataWrite <= wr;
    dataRead <= !wr;
    indirect <= ind;
    indirectViaOne <= one;
    bitAccess <= bt;
    dataAddr <= a;
    dataWdata <= d;
    bitWdata <= d[0];
    @(posedge clk);
    dataWrite <= 1'b0;
    dataRead <= 1'b0;
    #1;
  endtask
  task automatic wd(input logic [7:0] a, d);
    dacc(1'b1, 1'b0, 1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    dacc(1'b0, 1'b0, 1'b0, 1'b0, a, 8'h00);
    check(dataRdata, exp);
  endtask
  task automatic mem(input logic cr, er, ew, fm, input logic [15:0] a);
    @(posedge clk);
    codeRead <= cr;
    extRead <= er;
    extWrite <= ew;
    flashWriteMode <= fm;
    codeAddr <= a;
    extAddr <= a;
    @(posedge clk);
    {codeRead, extRead, extWrite} <= 3'h0;
    #1;
  endtask
  task automatic ev(input logic e, c, r, input logic [7:0] p, m, b);
    @(posedge clk);
    intEntry <= e;
    intFromCan <= c;
    intReturn <= r;
    @(posedge clk);
    {intEntry, intFromCan, intReturn} <= 3'h0;
    #1;
    check({pageSelect, pageStackMiddle}, {p, m});
    check(pageStackBottom, b);
  endtask
  task automatic pushb(input logic [7:0] d, sp);
    @(posedge clk);
    push <= 1'b1;
    pushData <= d;
    @(posedge clk);
    push <= 1'b0;
    #1;
    check(stackPointer, sp);
    rd(sp, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({pageSelect, stackPointer}, 16'h0007);
    check({pageStackMiddle, pageStackBottom}, 16'h0000);
    check(autoPageEnable, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_space();
    mem(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
    check({flashRead, codeReserved}, 2'h2);
    mem(1'b1, 1'b0, 1'b0, 1'b0, memmap_pkg::LOCK_32K);
    check(lockByteHit, 1'b1);
    mem(1'b1, 1'b0, 1'b0, 1'b0, 16'h7c00);
    check(codeReserved, 1'b1);
    mem(1'b0, 1'b0, 1'b1, 1'b0, 16'h07ff);
    check({xramWrite, flashWrite, xramAddr}, {2'h2, 11'h7ff});
    mem(1'b0, 1'b0, 1'b1, 1'b1, 16'h1234);
    check({xramWrite, flashWrite}, 2'h1);
    mem(1'b0, 1'b1, 1'b0, 1'b1, 16'h0123);
    check({xramRead, xramAddr}, {1'b1, 11'h123});
    $display("test spaces done");
  endtask
  task automatic t_ram();
    pushb(8'hab, 8'h08);
    pushb(8'hcd, 8'h09);
    wd(8'hd0, 8'h10);
    check(programStatusWord, 8'h10);
    wd(8'h10, 8'h40);
    wd(8'h11, 8'h90);
    wd(8'h40, 8'h5a);
    dacc(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
    check(dataRdata, 8'h5a);
    dacc(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h77);
    check(sfrWrite, 1'b0);
    dacc(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
    check(dataRdata, 8'h77);
    rd(8'h90, 8'hff);
    wd(8'h22, 8'h00);
    dacc(1'b1, 1'b0, 1'b0, 1'b1, 8'h13, 8'h01);
    dacc(1'b1, 1'b0, 1'b0, 1'b1, 8'h17, 8'h01);
    rd(8'h22, 8'h88);
    dacc(1'b0, 1'b0, 1'b0, 1'b1, 8'h17, 8'h00);
    check(dataRdata, 8'h01);
    dacc(1'b1, 1'b0, 1'b0, 1'b1, 8'he3, 8'h01);
    check({sfrWrite, sfrBitAccess, sfrAddr}, {2'h3, 8'he0});
    $display("test ram done");
  endtask
  task automatic t_paging();
    wd(8'ha3, 8'h3c);
    check({sfrWrite, sfrUnoccupied, sfrAddr, page_select}, {2'h2, 8'ha3, 8'h00});
    @(posedge clk);
    #1;
    check({model.lastPage, model.lastData}, 16'h003c);
    dacc(1'b0, 1'b0, 1'b0, 1'b0, 8'ha3, 8'h00);
    check({sfrRead, dataRvalid}, 2'h2);
    wd(8'ha7, 8'h0f);
    check(pageSelect, 8'h0f);
    ev(1'b1, 1'b1, 1'b0, 8'h0c, 8'h0f, 8'h00);
    ev(1'b1, 1'b0, 1'b0, 8'h00, 8'h0c, 8'h0f);
    ev(1'b0, 1'b0, 1'b1, 8'h0c, 8'h0f, 8'h00);
    wd(8'ha7, 8'h0f);
    check({pageStackMiddle, pageStackBottom}, 16'h0f00);
    wd(8'h85, 8'h33);
    check({pageSelect, pageStackMiddle}, 16'h0f33);
    ev(1'b0, 1'b0, 1'b1, 8'h33, 8'h00, 8'h00);
    wd(8'ha3, 8'h55);
    check({sfrUnoccupied, sfrWdata}, {1'b1, 8'h55});
    wd(8'h90, 8'h5c);
    rd(8'h90, 8'h5c);
    wd(8'ha7, 8'h0f);
    wd(8'h84, 8'hfe);
    check(autoPageEnable, 1'b0);
    rd(8'h84, 8'h00);
    ev(1'b1, 1'b1, 1'b0, 8'h0f, 8'h00, 8'h00);
    ev(1'b0, 1'b0, 1'b1, 8'h0f, 8'h00, 8'h00);
    wd(8'h84, 8'h01);
    rd(8'h84, 8'h01);
    $display("test paging done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    rst = 1'b1;
    {codeRead, extRead, extWrite, flashWriteMode, dataRead, dataWrite} = 6'h00;
    {indirect, indirectViaOne, bitAccess, bitWdata, push} = 5'h00;
    {intEntry, intFromCan, intReturn} = 3'h0;
    {codeAddr, extAddr} = 32'h0;
    {dataAddr, dataWdata, pushData} = 24'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_space();
    t_ram();
    t_paging();
    conclude();
  end
endmodule
`default_nettype wire
